// >>> cpce_pkg.sv
/*
 * shared constants and carrier types for the current and power engine.
 * assumes a single 50 MHz clock domain and one shared, multiplexed adc.
 */
package cpce_pkg;

  // ****************************************************************
  // widths and timing
  // ****************************************************************
  localparam int unsigned SAMPLE_W    = 16;
  localparam int unsigned CAL_W       = 15;
  localparam int unsigned CUR_W       = 32;
  localparam int unsigned PWR_W       = 48;
  localparam int unsigned AVG_MAX     = 1024;
  localparam int unsigned AVG_W       = 11;
  localparam int unsigned ACC_GUARD   = 10;
  localparam int unsigned CLK_FREQ_MHZ = 50;
  localparam int unsigned DIV_CYCLES  = 64;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [CUR_W-1:0] CUR_RESET = 32'h0000_0000;
  localparam logic [PWR_W-1:0] PWR_RESET = 48'h0000_0000_0000;

  // ****************************************************************
  // adc input select, one shared converter
  // ****************************************************************
  typedef enum logic [1:0] {
    CPCE_CH_SHUNT = 2'b00,
    CPCE_CH_BUS   = 2'b01,
    CPCE_CH_TEMP  = 2'b10
  } cpce_chan_e;

  // one finished conversion from the sequencer
  typedef struct packed {
    logic                       valid;
    cpce_chan_e                 chan;
    logic signed [SAMPLE_W-1:0] data;
  } cpce_sample_s;

  // averaged results toward the output registers
  typedef struct packed {
    logic signed [CUR_W-1:0] current;
    logic signed [PWR_W-1:0] power;
  } cpce_result_s;

endpackage

// >>> cpce_divider.sv
/*
 * sequential signed divider by an unsigned count, restoring form.
 * assumes start is a one-cycle pulse and the divisor is never zero.
 */
`timescale 1ns/10ps
module cpce_divider #(
  parameter int unsigned NUM_W = 58,
  parameter int unsigned DEN_W = 11
) (
  // clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    nrst_in,
  // request
  input  wire logic                    start_in,
  input  wire logic signed [NUM_W-1:0] num_in,
  input  wire logic        [DEN_W-1:0] den_in,
  // answer
  output logic                         done_out,
  output logic signed [NUM_W-1:0]      quot_out
);
  import cpce_pkg::*;

  localparam int unsigned CNT_W = $clog2(NUM_W + 1);

  logic [NUM_W-1:0] mag_q;
  logic [NUM_W-1:0] quo_q;
  logic [DEN_W:0]   rem_q;
  logic [DEN_W-1:0] den_q;
  logic [CNT_W-1:0] cnt_q;
  logic             neg_q;
  logic             busy_q;
  logic [DEN_W:0]   trial;

  // one quotient bit per cycle, msb first
  always_comb begin
    trial = {rem_q[DEN_W-1:0], mag_q[NUM_W-1]};
  end

  // shift-subtract sequence
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      mag_q    <= '0;
      quo_q    <= '0;
      rem_q    <= '0;
      den_q    <= '0;
      cnt_q    <= '0;
      neg_q    <= 1'b0;
      busy_q   <= 1'b0;
      done_out <= 1'b0;
      quot_out <= '0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        mag_q  <= num_in[NUM_W-1] ? NUM_W'(-num_in) : num_in;
        neg_q  <= num_in[NUM_W-1];
        den_q  <= den_in;
        rem_q  <= '0;
        quo_q  <= '0;
        cnt_q  <= CNT_W'(NUM_W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        mag_q <= {mag_q[NUM_W-2:0], 1'b0};
        if (trial >= {1'b0, den_q}) begin
          rem_q <= trial - {1'b0, den_q};
          quo_q <= {quo_q[NUM_W-2:0], 1'b1};
        end else begin
          rem_q <= trial;
          quo_q <= {quo_q[NUM_W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - CNT_W'(1);
        if (cnt_q == CNT_W'(1)) begin
          busy_q   <= 1'b0;
          done_out <= 1'b1;
          quot_out <= neg_q ? NUM_W'(-{quo_q[NUM_W-2:0], 1'b1 & (trial >= {1'b0, den_q})})
                            : {quo_q[NUM_W-2:0], trial >= {1'b0, den_q}};
        end
      end
    end
  end

endmodule

// >>> cpce_engine.sv
/*
 * current and power calculation engine of a power monitor.
 * assumes a conversion sequencer that drives the shared adc mux and
 * reports each finished sample; results feed spi-readable registers.
 */
// Functional notes
// - compute only after shunt and bus samples
// - power uses current with newest bus
// - zero calibration forces zero power
// - averaging above one uses accumulator
// - add each result until count reached
// - load averages into outputs when done
// - arithmetic runs beside conversions, no stall
// - one mux selects input for adc
// - one averaging count, 1 to 1024, all inputs
// - outputs hold until next complete result
`timescale 1ns/10ps
module cpce_engine #(
  parameter int unsigned AVG_LIMIT = cpce_pkg::AVG_MAX
) (
  // clock and reset
  input  wire logic                            clock_in,
  input  wire logic                            nrst_in,
  // configuration
  input  wire logic [cpce_pkg::CAL_W-1:0]      shunt_cal_in,
  input  wire logic [cpce_pkg::AVG_W-1:0]      avg_count_in,
  input  wire logic                            seq_restart_in,
  // sequencer side
  input  wire cpce_pkg::cpce_chan_e            chan_req_in,
  input  wire cpce_pkg::cpce_sample_s          sample_in,
  output cpce_pkg::cpce_chan_e                 adc_sel_out,
  // result side
  output cpce_pkg::cpce_result_s               result_out,
  output logic                                 result_upd_out,
  output logic                                 busy_out
);
  import cpce_pkg::*;

  // ****************************************************************
  // local widths
  // ****************************************************************
  localparam int unsigned ACC_CUR_W = CUR_W + ACC_GUARD;
  localparam int unsigned ACC_PWR_W = PWR_W + ACC_GUARD;
  localparam int unsigned PROD_W    = SAMPLE_W + CAL_W + 1;

  typedef enum logic [1:0] {
    CPCE_IDLE = 2'b00,
    CPCE_DIVC = 2'b01,
    CPCE_DIVP = 2'b10
  } cpce_state_e;

  // clamps the configured count into 1 .. AVG_LIMIT
  function automatic logic [AVG_W-1:0] eff_count(input logic [AVG_W-1:0] c);
    if (c == '0) begin
      eff_count = AVG_W'(1);
    end else if (c > AVG_W'(AVG_LIMIT)) begin
      eff_count = AVG_W'(AVG_LIMIT);
    end else begin
      eff_count = c;
    end
  endfunction

  logic                       shunt_seen_q;
  logic signed [SAMPLE_W-1:0] shunt_q;
  logic [AVG_W-1:0]           run_cnt;
  logic signed [ACC_CUR_W-1:0] acc_cur_q;
  logic signed [ACC_PWR_W-1:0] acc_pwr_q;
  logic [AVG_W-1:0]           done_cnt_q;
  logic [AVG_W-1:0]           count_q;
  cpce_state_e                state_q;
  logic signed [CUR_W-1:0]    cur_d;
  logic signed [PWR_W-1:0]    pwr_d;
  logic                       calc_go;
  logic                       last_go;
  logic                       div_start;
  logic signed [ACC_PWR_W-1:0] div_num;
  logic                       div_done;
  logic signed [ACC_PWR_W-1:0] div_quot;

  // ****************************************************************
  // input mux follows the sequencer, one input at a time
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      adc_sel_out <= CPCE_CH_SHUNT;
    end else begin
      adc_sel_out <= chan_req_in;
    end
  end

  // ****************************************************************
  // per-sample arithmetic
  // ****************************************************************
  // current from latched shunt, power from that current and new bus
  always_comb begin
    cur_d = CUR_W'($signed(PROD_W'(shunt_q)) * $signed({1'b0, shunt_cal_in}));
    if (shunt_cal_in == '0) begin
      pwr_d = '0;
    end else begin
      pwr_d = PWR_W'(cur_d) * PWR_W'(sample_in.data);
    end
  end

  // a bus sample after a shunt sample completes one calculation
  assign calc_go = sample_in.valid && sample_in.chan == CPCE_CH_BUS && shunt_seen_q;
  // count of this run, taken fresh at its first calculation
  assign run_cnt = (done_cnt_q == '0) ? eff_count(avg_count_in) : count_q;
  assign last_go = calc_go && (done_cnt_q + AVG_W'(1) >= run_cnt);

  // latches the shunt sample of the present sequence
  always_ff @(posedge clock_in) begin
    if (!nrst_in || seq_restart_in) begin
      shunt_seen_q <= 1'b0;
      shunt_q      <= '0;
    end else if (sample_in.valid && sample_in.chan == CPCE_CH_SHUNT) begin
      shunt_seen_q <= 1'b1;
      shunt_q      <= sample_in.data;
    end else if (calc_go) begin
      shunt_seen_q <= 1'b0;
    end
  end

  // ****************************************************************
  // accumulator, cleared at the last calculation of each averaging run
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!nrst_in || seq_restart_in) begin
      acc_cur_q  <= '0;
      acc_pwr_q  <= '0;
      done_cnt_q <= '0;
      count_q    <= AVG_W'(1);
    end else if (calc_go) begin
      if (done_cnt_q == '0) begin
        count_q <= eff_count(avg_count_in);
      end
      if (last_go) begin
        acc_cur_q  <= '0;
        acc_pwr_q  <= '0;
        done_cnt_q <= '0;
      end else begin
        acc_cur_q  <= acc_cur_q + ACC_CUR_W'(cur_d);
        acc_pwr_q  <= acc_pwr_q + ACC_PWR_W'(pwr_d);
        done_cnt_q <= done_cnt_q + AVG_W'(1);
      end
    end
  end

  // ****************************************************************
  // averaging divide runs in the background, no sequencer stall
  // ****************************************************************
  logic signed [ACC_CUR_W-1:0] sum_cur_q;
  logic signed [ACC_PWR_W-1:0] sum_pwr_q;
  logic [AVG_W-1:0]            div_den_q;
  logic signed [CUR_W-1:0]     avg_cur_q;

  // captures final sums when the run completes
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      sum_cur_q <= '0;
      sum_pwr_q <= '0;
      div_den_q <= AVG_W'(1);
    end else if (last_go && state_q == CPCE_IDLE) begin
      sum_cur_q <= acc_cur_q + ACC_CUR_W'(cur_d);
      sum_pwr_q <= acc_pwr_q + ACC_PWR_W'(pwr_d);
      div_den_q <= run_cnt;
    end
  end

  // divider sequencing: current first, then power
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state_q        <= CPCE_IDLE;
      avg_cur_q      <= CUR_RESET;
      result_out     <= '{current: CUR_RESET, power: PWR_RESET};
      result_upd_out <= 1'b0;
      busy_out       <= 1'b0;
      div_start      <= 1'b0;
    end else begin
      result_upd_out <= 1'b0;
      div_start      <= 1'b0;
      unique case (state_q)
        CPCE_IDLE: begin
          if (last_go) begin
            state_q   <= CPCE_DIVC;
            div_start <= 1'b1;
            busy_out  <= 1'b1;
          end
        end
        CPCE_DIVC: begin
          if (div_done) begin
            avg_cur_q <= CUR_W'(div_quot);
            state_q   <= CPCE_DIVP;
            div_start <= 1'b1;
          end
        end
        CPCE_DIVP: begin
          if (div_done) begin
            result_out.current <= avg_cur_q;
            result_out.power   <= PWR_W'(div_quot);
            result_upd_out     <= 1'b1;
            busy_out           <= 1'b0;
            state_q            <= CPCE_IDLE;
          end
        end
        default: begin
          state_q <= CPCE_IDLE;
        end
      endcase
    end
  end

  assign div_num = (state_q == CPCE_DIVP) ? sum_pwr_q : ACC_PWR_W'(sum_cur_q);

  cpce_divider #(
    .NUM_W (ACC_PWR_W),
    .DEN_W (AVG_W)
  ) u_div (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .start_in (div_start),
    .num_in   (div_num),
    .den_in   (div_den_q),
    .done_out (div_done),
    .quot_out (div_quot)
  );

endmodule

// >>> cpce_engine_assertions.sv
/*
 * port checker for the current and power engine.
 * assumes a bind onto cpce_engine, one clock domain.
 */
`timescale 1ns/10ps
module cpce_engine_assertions #(
  parameter int unsigned AVG_LIMIT = 1024
) (
  // clock and reset
  input wire logic                       clock_in,
  input wire logic                       nrst_in,
  // inputs watched
  input wire logic [cpce_pkg::CAL_W-1:0] shunt_cal_in,
  input wire cpce_pkg::cpce_chan_e       chan_req_in,
  input wire cpce_pkg::cpce_sample_s     sample_in,
  // outputs watched
  input wire cpce_pkg::cpce_chan_e       adc_sel_out,
  input wire cpce_pkg::cpce_result_s     result_out,
  input wire logic                       result_upd_out,
  input wire logic                       busy_out
);
  import cpce_pkg::*;
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  wire bus_v = sample_in.valid && (sample_in.chan == CPCE_CH_BUS);
  a_sel_follows_req: assert property (nrst_in && $past(nrst_in) |-> adc_sel_out == $past(chan_req_in))
    else $error("adc select not a copy of request");
  a_result_holds: assert property (!result_upd_out && $past(nrst_in) |-> $stable(result_out))
    else $error("result changed without update");
  a_zero_cal_power: assert property (result_upd_out && shunt_cal_in == 0 |-> result_out.power == 0)
    else $error("power not zero with zero calibration");
  a_upd_one_cycle: assert property (result_upd_out |=> !result_upd_out)
    else $error("update pulse longer than one cycle");
  a_busy_ends_upd: assert property ($fell(busy_out) |-> result_upd_out)
    else $error("busy fell without update");
  a_result_in_time: assert property ($rose(busy_out) |-> ##[1:200] result_upd_out)
    else $error("result late after final calc");
  a_calc_after_bus: assert property ($rose(busy_out) |-> $past(bus_v, 1) || $past(bus_v, 2))
    else $error("calc started without bus sample");
  a_upd_after_busy: assert property (result_upd_out |-> $past(busy_out))
    else $error("update without divide phase");
endmodule

// >>> cpce_seq_model.sv
/*
 * conversion sequencer model: drives the adc select, reports samples.
 * assumes the bench calls convert one conversion at a time.
 */
`timescale 1ns/10ps
module cpce_seq_model #(
  parameter int CONV_CYC = 80
) (
  // clock
  input  wire logic              clock_in,
  // toward the engine
  output cpce_pkg::cpce_chan_e   chan_req_out,
  output cpce_pkg::cpce_sample_s sample_out
);
  import cpce_pkg::*;
  // idle values at time zero
  initial begin
    chan_req_out = CPCE_CH_SHUNT;
    sample_out = '0;
  end
  // one input at a time through the mux, one-cycle valid
  task automatic convert(input cpce_chan_e ch, input logic [SAMPLE_W-1:0] d);
    @(posedge clock_in);
    chan_req_out <= ch;
    repeat (CONV_CYC) @(posedge clock_in);
    sample_out <= '{1'b1, ch, d};
    @(posedge clock_in);
    sample_out <= '{1'b0, ch, ~d}; // stale data shown inverted
  endtask
endmodule

// >>> current_power_calc_engine_tb.sv
/*
 * self-checking bench for the current and power engine.
 * assumes the sequencer model and the port checker beside it.
 */
`timescale 1ns/10ps
module current_power_calc_engine_tb;
  import cpce_pkg::*;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic             clock_in = 1'b0;
  logic             nrst_in = 1'b0;
  logic [CAL_W-1:0] cal = 15'h0123;
  logic [AVG_W-1:0] avg = 11'h001;
  logic             restart = 1'b0;
  cpce_chan_e       chan_req;
  cpce_sample_s     smp;
  cpce_result_s     res;
  logic             upd;
  logic             busy;
  cpce_chan_e       sel;
  int               u0 = 0;
  int               n_errors = 0;
  int               check_count = 0;
  int               cyc = 0;
  int               upd_cnt = 0;
  longint           sum_c;
  longint           sum_p;
  always #10 clock_in = ~clock_in;
  cpce_engine dut (.clock_in(clock_in), .nrst_in(nrst_in), .shunt_cal_in(cal),
    .avg_count_in(avg), .seq_restart_in(restart), .chan_req_in(chan_req),
    .sample_in(smp), .adc_sel_out(sel), .result_out(res), .result_upd_out(upd),
    .busy_out(busy));
  cpce_seq_model seq (.clock_in(clock_in), .chan_req_out(chan_req), .sample_out(smp));
  // update counter and hang limit
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (upd === 1'b1) upd_cnt <= upd_cnt + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one shunt and bus pair, expected sums kept here
  task automatic pair(input logic signed [15:0] s, input logic signed [15:0] b);
    logic signed [31:0] c;
    logic signed [47:0] p;
    c = 32'(longint'(s) * longint'(cal));
    p = (cal == 0) ? 48'h0 : 48'(longint'(c) * longint'(b));
    sum_c += c;
    sum_p += p;
    seq.convert(CPCE_CH_SHUNT, s);
    seq.convert(CPCE_CH_BUS, b);
  endtask
  // a full averaging run, one update and the average expected
  task automatic run(input logic [AVG_W-1:0] cnt, input int n, input logic [15:0] s0,
                     input logic [15:0] b0);
    int u;
    logic [31:0] ec;
    logic [47:0] ep;
    @(posedge clock_in);
    avg <= cnt;
    sum_c = 0;
    sum_p = 0;
    u = upd_cnt;
    for (int i = 0; i < n; i++) begin
      pair(s0 + 16'(i * 37), b0 - 16'(i * 11));
    end
    repeat (150) @(posedge clock_in);
    ec = 32'(sum_c / n);
    ep = 48'(sum_p / n);
    chk(64'(upd_cnt - u), 64'h1);
    chk({32'h0, res.current}, {32'h0, ec});
    chk({16'h0, res.power}, {16'h0, ep});
    chk(64'(busy), 64'h0);
  endtask
  // restart pulse clearing pending samples
  task automatic pulse_restart();
    @(posedge clock_in);
    restart <= 1'b1;
    @(posedge clock_in);
    restart <= 1'b0;
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    chk({16'h0, res.power}, 64'h0);
    run(11'h001, 1, 16'h0100, 16'h0300);
    run(11'h004, 4, 16'hFE00, 16'h1000);
    run(11'h000, 1, 16'h7FFF, 16'h7FFF);
    cal <= 15'h0000;
    run(11'h002, 2, 16'h0400, 16'h0500);
    cal <= 15'h7FFF;
    pulse_restart();
    u0 = upd_cnt;
    seq.convert(CPCE_CH_BUS, 16'h1234);
    seq.convert(CPCE_CH_TEMP, 16'h0055);
    chk(64'(sel), 64'(CPCE_CH_TEMP));
    repeat (130) @(posedge clock_in);
    chk(64'(upd_cnt - u0), 64'h0);
    run(11'h001, 1, 16'h8001, 16'h0042);
    @(posedge clock_in);
    avg <= 11'h003;
    pair(16'h0100, 16'h0200);
    pulse_restart();
    run(11'h003, 3, 16'h0010, 16'h0020);
    end_sim();
  end
endmodule

bind cpce_engine cpce_engine_assertions #(.AVG_LIMIT(AVG_LIMIT)) chk_i (
  .clock_in(clock_in), .nrst_in(nrst_in), .shunt_cal_in(shunt_cal_in),
  .chan_req_in(chan_req_in), .sample_in(sample_in), .adc_sel_out(adc_sel_out),
  .result_out(result_out), .result_upd_out(result_upd_out), .busy_out(busy_out));
